// >>> hw/isd_core.sv
`timescale 1ns/1ps
`include "isd_map.svh"

// What this block does
// - Firmware version as four BCD nibbles
// - Build month and day as BCD bytes
// - Build year as four BCD nibbles
// - Fixed part code in product register
// - Lot serial number readable
// - Sensors sampled at fixed internal rate
// - Per-sensor averaging to base rate
// - External pulse starts averaged four-sample burst
// - External clock only when enabled, selected line
// - Output rate is base over decimation+1
// - External mode uses pulse rate as base
// - Average inertial data; orientation decimated only
// - Eleven-bit decimation, upper bits ignored, reset zero
// - Magnetometer and barometer internal update rates
// - External: magnetometer 1/24, barometer 1/48
// - Mag and baro rates ignore decimation
// - New-data flags set on fresh data
// - Reading mag or baro clears its flag
// - Sequence counter 1..48/(dec+1); one means new
module isd_core #(
    parameter int NCH = 6,
    parameter int SAMPLE_CYC = `ISD_SAMPLE_CYC,
    parameter logic [15:0] FW_VERSION = 16'h0100,
    parameter logic [15:0] BUILD_MONTH_DAY = 16'h0101,
    parameter logic [15:0] BUILD_YEAR = 16'h2000,
    parameter logic [15:0] PART_CODE = 16'h1234,  // Arbitrary value
    parameter logic [15:0] SERIAL_NUMBER = 16'h0001
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic [3:0] digital_io_line,
    input wire logic [NCH*16-1:0] sensor_in,
    input wire logic [15:0] orient_in,
    input wire logic [47:0] mag_in,
    input wire logic [15:0] baro_in,
    output logic sample_req,
    output logic [NCH*16-1:0] inertial_out,
    output logic inertial_valid,
    output logic [15:0] orient_out
);
    // Largest sequence count for a decimation setting
    function automatic logic [6:0] seq_max(input logic [10:0] d);
        int m;
        m = 1;
        for (int k = 1; k <= `ISD_SEQ_SPAN; k++) begin
            if (k * (int'(d) + 1) <= `ISD_SEQ_SPAN) begin
                m = k;
            end
        end
        return 7'(m);
    endfunction

    // Register hit test on page and even offset
    function automatic logic hit(input logic [7:0] pg, input logic [6:0] a,
                                 input logic [7:0] p, input logic [6:0] o);
        return (pg == p) && ({a[6:1], 1'b0} == o);
    endfunction

    // Pin synchronisers: stage 1 feeds stage 2 only
    logic [2:0] sp1_q, sp2_q, sp3_q;  // cs_n, sclk, mosi
    logic [3:0] dio1_q, dio2_q, dio3_q;

    // Serial and register state
    logic [15:0] rx_q, rx_d;      // Incoming command
    logic [15:0] tx_q, tx_d;      // Outgoing answer
    logic [15:0] rdata_q, rdata_d;  // Answer for next frame
    logic [3:0] bit_q, bit_d;     // Bits in the frame
    logic miso_q, miso_d;
    logic [7:0] page_q, page_d;   // Selected register page
    logic [15:0] dec_q, dec_d;    // Output decimation
    logic [7:0] fnc_q, fnc_d;     // Function io control
    logic [47:0] mag_q, mag_d;    // Magnetometer axis outputs
    logic [15:0] baro_q, baro_d;  // Barometer output
    logic mag_new_q, mag_new_d;
    logic baro_new_q, baro_new_d;
    logic frame_done;             // Sixteenth bit taken this cycle
    logic rd_mag, rd_baro;        // Reads that clear new-data flags

    // Sampling state
    isd_pkg::isd_state_t st_q, st_d;
    logic [$clog2(SAMPLE_CYC)-1:0] scnt_q, scnt_d;  // Cycles since last sample
    logic [1:0] nb_q, nb_d;       // Sample index in a burst
    logic [10:0] dcnt_q, dcnt_d;  // Base samples since last output
    logic [5:0] bcnt_q, bcnt_d;   // Base samples, mod 48
    logic [6:0] seq_q, seq_d;     // Sample sequence counter
    logic baro_seen_q, baro_seen_d;
    logic [15:0] orient_q, orient_d;
    logic samp_req_q;
    logic samp_stb, base_stb, out_stb, mag_tick, baro_tick;
    logic ext, dio_edge;
    logic [NCH-1:0] ch_done;

    // Synchroniser flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Idle pin levels: deselected, clock high, so no false edge follows reset
            sp1_q <= 3'h6;
            sp2_q <= 3'h6;
            sp3_q <= 3'h6;
            dio1_q <= 4'h0;
            dio2_q <= 4'h0;
            dio3_q <= 4'h0;
        end else begin
            sp1_q <= {spi_cs_n, spi_sclk, spi_mosi};
            sp2_q <= sp1_q;
            sp3_q <= sp2_q;
            dio1_q <= digital_io_line;
            dio2_q <= dio1_q;
            dio3_q <= dio2_q;
        end
    end

    // Serial frames and register reads and writes
    always_comb begin
        logic [15:0] cmd;
        logic [6:0] a;
        cmd = {rx_q[14:0], sp2_q[0]};
        a = cmd[`ISD_CMD_ADDR_HI:`ISD_CMD_ADDR_LO];
        rx_d = rx_q;
        tx_d = tx_q;
        rdata_d = rdata_q;
        bit_d = bit_q;
        miso_d = miso_q;
        page_d = page_q;
        dec_d = dec_q;
        fnc_d = fnc_q;
        frame_done = 1'b0;
        rd_mag = 1'b0;
        rd_baro = 1'b0;
        if (sp2_q[2]) begin
            // Deselected: drop a partial frame
            bit_d = 4'h0;
        end else if (sp3_q[2]) begin
            // Frame start: load the pending answer
            tx_d = rdata_q;
            miso_d = rdata_q[15];
        end else if (!sp2_q[1] && sp3_q[1]) begin
            // Falling clock: drive next answer bit
            miso_d = tx_q[15];
            tx_d = {tx_q[14:0], 1'b0};
        end else if (sp2_q[1] && !sp3_q[1]) begin
            // Rising clock: take a command bit
            rx_d = cmd;
            bit_d = bit_q + 4'h1;
            frame_done = (bit_q == 4'hf);
        end
        if (frame_done && cmd[`ISD_CMD_WRITE_BIT]) begin
            // Byte write; offset zero selects the page
            if (a == `ISD_OFF_PAGE) begin
                page_d = cmd[7:0];
            end else if (page_q == `ISD_PAGE_3) begin
                // decimation written a byte at a time
                if (a == `ISD_OFF_DEC) begin
                    dec_d[7:0] = cmd[7:0];
                end else if (a == (`ISD_OFF_DEC + 7'h01)) begin
                    dec_d[15:8] = cmd[7:0];
                end else if (a == `ISD_OFF_FNCIO) begin
                    fnc_d = cmd[7:0];
                end
            end
        end else if (frame_done) begin
            rdata_d = 16'h0000;
            if (hit(page_q, a, page_q, `ISD_OFF_PAGE)) begin
                rdata_d = {8'h00, page_q};
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_SEQ)) begin
                rdata_d = {9'h000, seq_q};
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_SYSFLAG)) begin
                rdata_d[`ISD_FLAG_BARO] = baro_new_q;
                rdata_d[`ISD_FLAG_MAG] = mag_new_q;
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_MAG_X)) begin
                rdata_d = mag_q[15:0];
                rd_mag = 1'b1;
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_MAG_Y)) begin
                rdata_d = mag_q[31:16];
                rd_mag = 1'b1;
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_MAG_Z)) begin
                rdata_d = mag_q[47:32];
                rd_mag = 1'b1;
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_BARO)) begin
                rdata_d = baro_q;
                rd_baro = 1'b1;
            end else if (hit(page_q, a, `ISD_PAGE_0, `ISD_OFF_PART)) begin
                rdata_d = PART_CODE;
            end else if (hit(page_q, a, `ISD_PAGE_3, `ISD_OFF_DEC)) begin
                rdata_d = dec_q;
            end else if (hit(page_q, a, `ISD_PAGE_3, `ISD_OFF_FNCIO)) begin
                rdata_d = {8'h00, fnc_q};
            end else if (hit(page_q, a, `ISD_PAGE_3, `ISD_OFF_FWVER)) begin
                rdata_d = FW_VERSION;
            end else if (hit(page_q, a, `ISD_PAGE_3, `ISD_OFF_MONTHDAY)) begin
                rdata_d = BUILD_MONTH_DAY;
            end else if (hit(page_q, a, `ISD_PAGE_3, `ISD_OFF_YEAR)) begin
                rdata_d = BUILD_YEAR;
            end else if (hit(page_q, a, `ISD_PAGE_4, `ISD_OFF_SERIAL)) begin
                rdata_d = SERIAL_NUMBER;
            end
        end
        mag_d = mag_tick ? mag_in : mag_q;
        baro_d = baro_tick ? baro_in : baro_q;
        mag_new_d = mag_tick | (mag_new_q & ~rd_mag);
        baro_new_d = baro_tick | (baro_new_q & ~rd_baro);
    end

    // Serial and register flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            rdata_q <= 16'h0000;
            bit_q <= 4'h0;
            miso_q <= 1'b0;
            page_q <= `ISD_PAGE_0;
            dec_q <= `ISD_DEC_RST;
            fnc_q <= `ISD_FNC_RST;
            mag_q <= 48'h000000000000;
            baro_q <= 16'h0000;
            mag_new_q <= 1'b0;
            baro_new_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            tx_q <= tx_d;
            rdata_q <= rdata_d;
            bit_q <= bit_d;
            miso_q <= miso_d;
            page_q <= page_d;
            dec_q <= dec_d;
            fnc_q <= fnc_d;
            mag_q <= mag_d;
            baro_q <= baro_d;
            mag_new_q <= mag_new_d;
            baro_new_q <= baro_new_d;
        end
    end

    // external clock enable and line select
    assign ext = fnc_q[`ISD_FNC_EXT_EN];
    assign dio_edge = dio2_q[fnc_q[`ISD_FNC_SEL_HI:`ISD_FNC_SEL_LO]]
                    & ~dio3_q[fnc_q[`ISD_FNC_SEL_HI:`ISD_FNC_SEL_LO]];

    // Sample sequencer, decimation and slow-sensor timing
    always_comb begin
        logic tick;
        tick = (scnt_q == ($clog2(SAMPLE_CYC))'(SAMPLE_CYC - 1));
        st_d = st_q;
        scnt_d = scnt_q;
        nb_d = nb_q;
        samp_stb = 1'b0;
        case (st_q)
            isd_pkg::ISD_IDLE: begin
                scnt_d = '0;
                nb_d = 2'h0;
                if (!ext) begin
                    st_d = isd_pkg::ISD_RUN;
                end else if (dio_edge) begin
                    samp_stb = 1'b1;
                    nb_d = 2'h1;
                    st_d = isd_pkg::ISD_RUN;
                end
            end
            isd_pkg::ISD_RUN: begin
                scnt_d = tick ? '0 : scnt_q + 1'b1;
                samp_stb = tick;
                if (tick) begin
                    nb_d = nb_q + 2'h1;
                end
                if (ext && ((tick && nb_q == 2'h3) || (!tick && nb_q == 2'h0))) begin
                    st_d = isd_pkg::ISD_IDLE;
                end
            end
            default: begin
                st_d = isd_pkg::ISD_IDLE;
            end
        endcase
        // base sample closes each burst in either mode
        base_stb = samp_stb && (nb_q == 2'h3);
        out_stb = base_stb && (dcnt_q >= dec_q[`ISD_DEC_HI:0]);
        dcnt_d = out_stb ? 11'h000 : (base_stb ? dcnt_q + 11'h001 : dcnt_q);
        // slow sensors count base samples only
        bcnt_d = base_stb ? ((bcnt_q == 6'(`ISD_BARO_DIV - 1)) ? 6'h00 : bcnt_q + 6'h01)
                          : bcnt_q;
        // every 24th and 48th base sample
        mag_tick = base_stb && ((bcnt_q == 6'(`ISD_MAG_DIV - 1))
                             || (bcnt_q == 6'(`ISD_BARO_DIV - 1)));
        baro_tick = base_stb && (bcnt_q == 6'(`ISD_BARO_DIV - 1));
        baro_seen_d = out_stb ? 1'b0 : (baro_seen_q | baro_tick);
        seq_d = seq_q;
        if (out_stb) begin
            if (baro_seen_q || baro_tick || seq_q >= seq_max(dec_q[`ISD_DEC_HI:0])) begin
                seq_d = 7'h01;
            end else begin
                seq_d = seq_q + 7'h01;
            end
        end
        orient_d = out_stb ? orient_in : orient_q;
    end

    // Sampling flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= isd_pkg::ISD_IDLE;
            scnt_q <= '0;
            nb_q <= 2'h0;
            dcnt_q <= 11'h000;
            bcnt_q <= 6'h00;
            seq_q <= `ISD_SEQ_RST;
            baro_seen_q <= 1'b0;
            orient_q <= 16'h0000;
            samp_req_q <= 1'b0;
        end else begin
            st_q <= st_d;
            scnt_q <= scnt_d;
            nb_q <= nb_d;
            dcnt_q <= dcnt_d;
            bcnt_q <= bcnt_d;
            seq_q <= seq_d;
            baro_seen_q <= baro_seen_d;
            orient_q <= orient_d;
            samp_req_q <= samp_stb;
        end
    end

    // one averaging and decimation stage per sensor
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        isd_avg_dec #(.W(16), .DW(11)) u_ch (
            .clk(clk),
            .nrst(nrst),
            .samp_stb(samp_stb),
            .base_stb(base_stb),
            .out_stb(out_stb),
            .dec(dec_q[`ISD_DEC_HI:0]),
            .sample_in(sensor_in[c*16 +: 16]),
            .avg_q(inertial_out[c*16 +: 16]),
            .done_q(ch_done[c])
        );
    end

    assign spi_miso = miso_q;
    assign sample_req = samp_req_q;
    assign inertial_valid = ch_done[0];
    assign orient_out = orient_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    part_code_a: assert property (frame_done && !rx_d[15] && page_q == 8'h00
        && rx_d[14:8] == 7'h7e |=> rdata_q == PART_CODE) else $error("bad part code");
    fw_version_a: assert property (frame_done && !rx_d[15] && page_q == 8'h03
        && rx_d[14:8] == 7'h78 |=> rdata_q == FW_VERSION) else $error("bad fw version");
    out_spacing_a: assert property (out_stb |-> base_stb
        && dcnt_q >= dec_q[10:0]) else $error("early output");
    ext_gate_a: assert property (st_q == isd_pkg::ISD_IDLE
        && !(ext && dio_edge) |-> !samp_stb) else $error("sample without pulse");
    burst_end_a: assert property (ext && base_stb
        |=> st_q == isd_pkg::ISD_IDLE) else $error("burst not ended");
    baro_mag_a: assert property (baro_tick |-> mag_tick ##1 (mag_new_q
        && baro_new_q)) else $error("slow flags not set");
    flag_clear_a: assert property (rd_mag && !mag_tick |=> !mag_new_q)
        else $error("mag flag not cleared");
    seq_one_a: assert property (out_stb && baro_tick |=> seq_q == 7'h01)
        else $error("seq not one");
    seq_step_a: assert property (out_stb && !baro_tick && !baro_seen_q
        && seq_q < seq_max(dec_q[10:0]) |=> seq_q == $past(seq_q) + 7'h01)
        else $error("seq step wrong");
    dec_rst_a: assert property ($rose(nrst) |-> dec_q == 16'h0000)
        else $error("dec not reset");

    ext_burst_c: cover property (ext && dio_edge ##1 st_q == isd_pkg::ISD_RUN);
    output_c: cover property (out_stb && dec_q[10:0] != 11'h000);
    baro_c: cover property (baro_tick && out_stb);
    read_mag_c: cover property (rd_mag && mag_new_q);
endmodule

// >>> common/isd_map.svh
`ifndef ISD_MAP_SVH
`define ISD_MAP_SVH

// Clock and sampling timing
`define ISD_CLK_HZ 250000000
`define ISD_SAMPLE_HZ 9840
`define ISD_SAMPLE_CYC (`ISD_CLK_HZ / `ISD_SAMPLE_HZ)
`define ISD_BURST_LEN 4
`define ISD_MAG_DIV 24
`define ISD_BARO_DIV 48
`define ISD_SEQ_SPAN 48

// Serial command word layout
`define ISD_CMD_WRITE_BIT 15
`define ISD_CMD_ADDR_HI 14
`define ISD_CMD_ADDR_LO 8
`define ISD_FRAME_BITS 16

// Page numbers
`define ISD_PAGE_0 8'h00
`define ISD_PAGE_3 8'h03
`define ISD_PAGE_4 8'h04

// Register offsets (byte addresses inside a page)
`define ISD_OFF_PAGE 7'h00
`define ISD_OFF_SEQ 7'h06
`define ISD_OFF_SYSFLAG 7'h08
`define ISD_OFF_MAG_X 7'h10
`define ISD_OFF_MAG_Y 7'h12
`define ISD_OFF_MAG_Z 7'h14
`define ISD_OFF_BARO 7'h16
`define ISD_OFF_PART 7'h7e
`define ISD_OFF_FNCIO 7'h06
`define ISD_OFF_DEC 7'h0c
`define ISD_OFF_FWVER 7'h78
`define ISD_OFF_MONTHDAY 7'h7a
`define ISD_OFF_YEAR 7'h7c
`define ISD_OFF_SERIAL 7'h20

// Field positions and reset values
`define ISD_FNC_EXT_EN 7
`define ISD_FNC_SEL_HI 5
`define ISD_FNC_SEL_LO 4
`define ISD_FLAG_BARO 9
`define ISD_FLAG_MAG 8
`define ISD_DEC_HI 10
`define ISD_DEC_RST 16'h0000
`define ISD_FNC_RST 8'h00
`define ISD_SEQ_RST 7'h01

`endif

// >>> common/isd_pkg.sv
package isd_pkg;
    // Sample sequencer states, one-hot
    typedef enum logic [1:0] {
        ISD_IDLE = 2'b01,
        ISD_RUN  = 2'b10
    } isd_state_t;
endpackage

// >>> hw/isd_avg_dec.sv
`timescale 1ns/1ps
`include "isd_map.svh"

// One sensor channel: 4x average, then boxcar over (decimation + 1) base samples
module isd_avg_dec #(
    parameter int W = 16,
    parameter int DW = 11
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic samp_stb,
    input wire logic base_stb,
    input wire logic out_stb,
    input wire logic [DW-1:0] dec,
    input wire logic [W-1:0] sample_in,
    output logic [W-1:0] avg_q,
    output logic done_q
);
    localparam int AW = W + DW + 2;
    localparam int CW = $clog2(AW + 1);

    logic signed [AW-1:0] sum4_q, sum4_d;  // Sum of the current burst
    logic signed [AW-1:0] acc_q, acc_d;    // Sum of base samples
    logic [AW-1:0] num_q, num_d;           // Dividend magnitude, then quotient
    logic [DW+1:0] rem_q, rem_d;           // Partial remainder
    logic [DW:0] div_q, div_d;             // Divisor, decimation + 1
    logic [CW-1:0] cnt_q, cnt_d;           // Divide steps left
    logic neg_q, neg_d;                    // Sign of the dividend
    logic [W-1:0] avg_d;
    logic done_d;

    // Next values: accumulate, then run a restoring divider
    always_comb begin
        logic signed [AW-1:0] s4;
        logic signed [AW-1:0] a4;
        logic signed [AW-1:0] tot;
        logic [DW+1:0] t;
        s4 = sum4_q + AW'(signed'(sample_in));
        a4 = s4 >>> 2;
        tot = acc_q + a4;
        t = {rem_q[DW:0], num_q[AW-1]};
        sum4_d = sum4_q;
        acc_d = acc_q;
        num_d = num_q;
        rem_d = rem_q;
        div_d = div_q;
        cnt_d = cnt_q;
        neg_d = neg_q;
        avg_d = avg_q;
        done_d = 1'b0;
        // four samples averaged per base sample
        if (samp_stb) begin
            sum4_d = base_stb ? '0 : s4;
        end
        if (base_stb) begin
            acc_d = out_stb ? '0 : tot;
        end
        // start dividing by decimation plus one
        if (base_stb && out_stb) begin
            neg_d = tot[AW-1];
            num_d = tot[AW-1] ? AW'(-tot) : AW'(tot);
            rem_d = '0;
            div_d = (DW+1)'(dec) + (DW+1)'(1);
            cnt_d = CW'(AW);
        end else if (cnt_q != '0) begin
            // One quotient bit per clock
            if (t >= (DW+2)'(div_q)) begin
                rem_d = t - (DW+2)'(div_q);
                num_d = {num_q[AW-2:0], 1'b1};
            end else begin
                rem_d = t;
                num_d = {num_q[AW-2:0], 1'b0};
            end
            cnt_d = cnt_q - CW'(1);
            if (cnt_q == CW'(1)) begin
                avg_d = neg_q ? W'(-num_d) : W'(num_d);
                done_d = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sum4_q <= '0;
            acc_q <= '0;
            num_q <= '0;
            rem_q <= '0;
            div_q <= '0;
            cnt_q <= '0;
            neg_q <= 1'b0;
            avg_q <= '0;
            done_q <= 1'b0;
        end else begin
            sum4_q <= sum4_d;
            acc_q <= acc_d;
            num_q <= num_d;
            rem_q <= rem_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            neg_q <= neg_d;
            avg_q <= avg_d;
            done_q <= done_d;
        end
    end
endmodule

// >>> testbench/isd_host.sv
`timescale 1ns/1ps
// Host processor model: serial register master, clock idle high, MSB first
module isd_host (
    input wire logic clk,
    input wire logic spi_miso,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi
);
    // Idle: deselected, serial clock parked high
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b1;
        spi_mosi = 1'b0;
    end
    // One 16-bit frame, half period of 6 clk, answer taken at each rise
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        @(negedge clk);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (6) @(negedge clk);
            spi_sclk = 1'b0;
            spi_mosi = cmd[i];
            repeat (6) @(negedge clk);
            spi_sclk = 1'b1;
            rsp[i] = spi_miso;
        end
        repeat (6) @(negedge clk);
        spi_cs_n = 1'b1;
        // Released data line must not keep its last value
        spi_mosi = ~spi_mosi;
        repeat (6) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] pg, input logic [6:0] off, input logic [15:0] val);
        logic [15:0] r;
        xfer({1'b1, 7'h00, pg}, r);
        xfer({1'b1, off, val[7:0]}, r);
        xfer({1'b1, off | 7'h01, val[15:8]}, r);
    endtask
    // Page, read command, then a filler frame brings the answer
    task automatic rd_reg(input logic [7:0] pg, input logic [6:0] off, output logic [15:0] val);
        logic [15:0] r;
        xfer({1'b1, 7'h00, pg}, r);
        xfer({1'b0, off, 8'h00}, r);
        xfer(16'h0000, val);
    endtask
endmodule

// >>> testbench/tb_imu_sample_decimation_ident.sv
`timescale 1ns/1ps
// Bench for sampling, decimation, flags and identification words
module tb_imu_sample_decimation_ident;
    logic clk = 1'b0; // Core clock, 4 ns period
    logic nrst = 1'b0; // Reset, active low
    logic [3:0] dio = 4'h0; // External clock lines
    logic cs_n, sclk, mosi, miso, sreq, ivld;
    logic [95:0] iout; // Six averaged channels
    logic [15:0] oout, v;
    int fails = 0;
    int comparisons = 0;
    int nvld = 0; // Count of result pulses
    int nreq = 0; // Count of sample requests
    logic [95:0] sens = {6{16'h0123}}; // Raw samples, all channels
    logic [15:0] orin = 16'h0b0d; // Orientation input
    logic [47:0] magv = 48'h0303_0202_0101; // Magnetometer input
    logic [15:0] barov = 16'h0505; // Barometer input
    // Free running clock
    initial begin
        forever #2 clk = ~clk;
    end
    // Counts result pulses and sample requests where they are settled
    always @(negedge clk) begin
        if (ivld === 1'b1) begin
            nvld++;
        end
        if (sreq === 1'b1) begin
            nreq++;
        end
    end
    isd_host u_isd_host (.clk(clk), .spi_miso(miso), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_mosi(mosi));
    // Part code below is an arbitrary value
    isd_core #(.SAMPLE_CYC(8), .FW_VERSION(16'h0102), .BUILD_MONTH_DAY(16'h1127),
        .BUILD_YEAR(16'h2013), .PART_CODE(16'h5a3c), .SERIAL_NUMBER(16'h0417)) u_isd_core (
        .clk(clk), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .digital_io_line(dio), .sensor_in(sens),
        .orient_in(orin), .mag_in(magv), .baro_in(barov),
        .sample_req(sreq), .inertial_out(iout), .inertial_valid(ivld), .orient_out(oout));
    // Counts, verdict, end of run
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares one value against its expectation
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reads a register and compares the masked value
    task automatic rc(input logic [7:0] p, input logic [6:0] o, input logic [15:0] m,
        input logic [15:0] e);
        u_isd_host.rd_reg(p, o, v);
        chk(v & m, e);
    endtask
    // Bounded wait for a result pulse, counted in cycles
    task automatic wait_vld(output int n);
        n = 0;
        while (ivld !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 4000) begin
                fails++;
                end_sim();
            end
        end
    endtask
    task automatic pulse(input logic [3:0] line);
        dio = line;
        repeat (4) @(negedge clk);
        dio = 4'h0;
        repeat (44) @(negedge clk);
    endtask
    // Identification words and decimation register
    task automatic t_regs();
        rc(8'h03, 7'h78, 16'hffff, 16'h0102); // firmware digits
        rc(8'h03, 7'h7a, 16'hffff, 16'h1127); // month and day
        rc(8'h03, 7'h7c, 16'hffff, 16'h2013); // year digits
        rc(8'h00, 7'h7e, 16'hffff, 16'h5a3c); // part code
        rc(8'h04, 7'h20, 16'hffff, 16'h0417); // serial number
        rc(8'h03, 7'h0c, 16'hffff, 16'h0000); // reset value
        u_isd_host.wr_reg(8'h03, 7'h0c, 16'h0018);
        rc(8'h03, 7'h0c, 16'hffff, 16'h0018); // paged write
        u_isd_host.wr_reg(8'h03, 7'h0c, 16'hf801);
        rc(8'h03, 7'h0c, 16'hffff, 16'hf801); // stored word
    endtask
    // Internal rate with upper decimation bits set, averaged values
    task automatic t_rate();
        int n;
        int r0;
        wait_vld(n);
        @(negedge clk);
        r0 = nreq;
        wait_vld(n);
        chk(16'(n + 1), 16'h0040); // two base periods
        chk(16'(nreq - r0), 16'h0008); // four samples per base
        for (int c = 0; c < 6; c++) begin
            chk(iout[c*16+:16], 16'h0123); // averaged channel
        end
        chk(oout, 16'h0b0d); // orientation decimated
        u_isd_host.rd_reg(8'h00, 7'h06, v);
        chk(16'(v >= 16'h0001 && v <= 16'h0018), 16'h0001); // count range
    endtask
    // External pulses: line select, burst per pulse, new-data flags
    task automatic t_ext();
        int n0;
        int r0;
        u_isd_host.wr_reg(8'h03, 7'h06, 16'h00a0);
        n0 = nvld;
        r0 = nreq;
        repeat (4) pulse(4'h1);
        chk(16'(nvld - n0), 16'h0000); // other line ignored
        chk(16'(nreq - r0), 16'h0000); // no samples taken
        rc(8'h00, 7'h16, 16'hffff, 16'h0505); // barometer latched
        rc(8'h00, 7'h10, 16'hffff, 16'h0101); // magnetometer latched
        rc(8'h00, 7'h08, 16'h0300, 16'h0000); // flags cleared
        magv = 48'h0303_0202_0111;
        barov = 16'h0515;
        n0 = nvld;
        r0 = nreq;
        repeat (48) pulse(4'h4);
        repeat (100) @(negedge clk);
        chk(16'(nvld - n0), 16'h0018); // one base per pulse
        chk(16'(nreq - r0), 16'h00c0); // four samples per pulse
        rc(8'h00, 7'h08, 16'h0300, 16'h0300); // both updated
        rc(8'h00, 7'h10, 16'hffff, 16'h0111); // magnetometer word
        rc(8'h00, 7'h16, 16'hffff, 16'h0515); // barometer word
        rc(8'h00, 7'h08, 16'h0300, 16'h0000); // cleared by reads
    endtask
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_regs();
        t_rate();
        t_ext();
        end_sim();
    end
endmodule
